// >>> hdl/esr_consts.svh
// Offsets, field positions, reset values and sizes of the event router
`ifndef ESR_CONSTS_SVH
`define ESR_CONSTS_SVH

`define ESR_OFS_EV_STATUS   8'h00
`define ESR_OFS_EV_CLEAR    8'h04
`define ESR_OFS_EV_MASK     8'h08
`define ESR_OFS_DB_ROUTE    8'h10
`define ESR_OFS_RXQ_ROUTE   8'h30
`define ESR_OFS_DB_STATUS   8'h40
`define ESR_OFS_DB_CLEAR    8'h50
`define ESR_OFS_RXQ_STATUS  8'h60
`define ESR_OFS_RXQ_CLEAR   8'h64

`define ESR_BIT_RESET_REQ   16
`define ESR_BIT_PORT_ERR    8
`define ESR_BIT_LOG_ERR     2
`define ESR_BIT_PW_IN       1
`define ESR_BIT_MCAST       0
`define ESR_EV_IMPL_MASK    32'h0001_0f07
`define ESR_RST_WORD        32'h0000_0000

`define ESR_NUM_PORTS       4
`define ESR_NUM_DB          4
`define ESR_DB_CONDS        16
`define ESR_NUM_RXQ         8
`define ESR_ROUTE_W         4
`define ESR_NUM_CPU_INT     16

`endif

// >>> hdl/esr_pkg.sv
// Types shared by the event status and routing block
package esr_pkg;
`include "esr_consts.svh"

   typedef logic [31:0] esr_word_t;
   typedef logic [7:0]  esr_addr_t;

   typedef struct packed {
      esr_word_t                                  ev_status;
      esr_word_t                                  ev_mask;
      logic [2*`ESR_NUM_DB-1:0][31:0]             db_route;
      esr_word_t                                  rxq_route;
      logic [`ESR_NUM_DB-1:0][`ESR_DB_CONDS-1:0]  db_status;
      logic [`ESR_NUM_RXQ-1:0]                    rxq_status;
      esr_word_t                                  rdata;
   } esr_state_t;

endpackage

// >>> hdl/esr_route.sv
// Steers pending conditions onto CPU interrupt lines by 4-bit route fields
`timescale 1ns/10ps
module esr_route #(
   parameter int NCOND = 72,
   parameter int NOUT  = 16
) (
   input  wire logic [NCOND-1:0]   pend_i,
   input  wire logic [NCOND*4-1:0] route_i,
   output logic      [NOUT-1:0]    line_o
);

   // Wired-OR per line: many conditions may share one CPU input
   always_comb begin
      line_o = '0;
      for (int c = 0; c < NCOND; c++) begin
         if (pend_i[c]) begin
            line_o[route_i[c*4 +: 4]] = 1'b1;
         end
      end
   end

endmodule // esr_route

// >>> hdl/esr_top.sv
// Event status, clear, mask and condition routing registers
`timescale 1ns/10ps
`include "esr_consts.svh"

// Overview of operation
// - A device reset request from any port sets status bit 16, held until cleared.
// - A logical layer error capture sets status bit 2.
// - An inbound port-write request on any port sets status bit 1.
// - A multicast event control symbol on any port sets status bit 0.
// - Port 3..0 errors sit at bits 11..8; reserved status bits read zero.
// - Writing one to a clear register bit clears the matching status flag.
// - Doorbell conditions 0-7 routed by eight 4-bit fields, condition 0 lowest.
// - Conditions 8-15 use a second register; each of four doorbells has a pair.
// - Receive queues 0-7 have eight readable, writable route fields reset zero.
module esr_top (
   input  wire logic                          CLK_I,
   input  wire logic                          ARST_N_I,
   input  wire logic                          CE_I,
   input  wire esr_pkg::esr_addr_t            ADDR_I,
   input  wire esr_pkg::esr_word_t            WDATA_I,
   input  wire logic                          WR_I,
   input  wire logic                          RD_I,
   output esr_pkg::esr_word_t                 RDATA_O,
   input  wire logic                          RESET_REQ_I,
   input  wire logic [`ESR_NUM_PORTS-1:0]     PORT_ERR_I,
   input  wire logic                          LOG_ERR_I,
   input  wire logic                          PW_IN_I,
   input  wire logic                          MCAST_I,
   input  wire logic [`ESR_NUM_DB*16-1:0]     DB_EVT_I,
   input  wire logic [`ESR_NUM_RXQ-1:0]       RXQ_EVT_I,
   output logic      [`ESR_NUM_CPU_INT-1:0]   CPU_INT_O,
   output logic                               IRQ_O
);
   import esr_pkg::*;

   localparam int NCOND = `ESR_NUM_DB * `ESR_DB_CONDS + `ESR_NUM_RXQ;

   esr_state_t s;
   esr_state_t next_s;

   esr_word_t  ev_set;
   esr_word_t  ev_clr;
   logic [NCOND-1:0]   pend;
   logic [NCOND*4-1:0] route;

   // Byte address of the n-th word above a base
   function automatic esr_addr_t word_at(input esr_addr_t base,
                                         input int        idx);
      word_at = base + 8'(idx * 4);
   endfunction

   // True for a write strobe on the given address
   function automatic logic wr_hit(input esr_addr_t a);
      wr_hit = WR_I && (ADDR_I == a);
   endfunction

   // Source events, all from logic on this clock, so no synchronisers
   always_comb begin
      ev_set = '0;
      ev_set[`ESR_BIT_RESET_REQ] = RESET_REQ_I;
      ev_set[`ESR_BIT_PORT_ERR +: `ESR_NUM_PORTS] = PORT_ERR_I;
      ev_set[`ESR_BIT_LOG_ERR] = LOG_ERR_I;
      ev_set[`ESR_BIT_PW_IN] = PW_IN_I;
      ev_set[`ESR_BIT_MCAST] = MCAST_I;
   end

   // clear only on implemented bits
   // Written out in full: a function that reads ports is blind to them here
   assign ev_clr = (WR_I && (ADDR_I == `ESR_OFS_EV_CLEAR)) ? WDATA_I : '0;

   always_comb begin
      next_s = s;
      next_s.rdata = '0;

      // sticky flags, reserved bits forced to zero
      // Set is ORed after the clear so a same-cycle event is not lost
      next_s.ev_status = ((s.ev_status & ~ev_clr) | ev_set)
                         & `ESR_EV_IMPL_MASK;

      if (wr_hit(`ESR_OFS_EV_MASK)) begin
         next_s.ev_mask = WDATA_I & `ESR_EV_IMPL_MASK;
      end

      for (int i = 0; i < 2 * `ESR_NUM_DB; i++) begin
         if (wr_hit(word_at(`ESR_OFS_DB_ROUTE, i))) begin
            next_s.db_route[i] = WDATA_I;
         end
      end

      if (wr_hit(`ESR_OFS_RXQ_ROUTE)) begin
         next_s.rxq_route = WDATA_I;
      end

      // Doorbell condition flags, write-one-to-clear, set wins
      for (int d = 0; d < `ESR_NUM_DB; d++) begin
         if (wr_hit(word_at(`ESR_OFS_DB_CLEAR, d))) begin
            next_s.db_status[d] = s.db_status[d] & ~WDATA_I[15:0];
         end
         next_s.db_status[d] = next_s.db_status[d]
                               | DB_EVT_I[d*16 +: 16];
      end

      // Receive queue condition flags, same clearing scheme
      if (wr_hit(`ESR_OFS_RXQ_CLEAR)) begin
         next_s.rxq_status = s.rxq_status & ~WDATA_I[7:0];
      end
      next_s.rxq_status = next_s.rxq_status | RXQ_EVT_I;

      // Read data is registered and valid only in the cycle after RD_I
      if (RD_I) begin
         case (ADDR_I)
            `ESR_OFS_EV_STATUS: begin
               next_s.rdata = s.ev_status & `ESR_EV_IMPL_MASK;
            end
            `ESR_OFS_EV_MASK: begin
               next_s.rdata = s.ev_mask;
            end
            `ESR_OFS_RXQ_ROUTE: begin
               next_s.rdata = s.rxq_route;
            end
            `ESR_OFS_RXQ_STATUS: begin
               next_s.rdata = {24'h00_0000, s.rxq_status};
            end
            default: begin
               // Clear registers are write-only and read zero
               next_s.rdata = '0;
            end
         endcase
         for (int i = 0; i < 2 * `ESR_NUM_DB; i++) begin
            if (ADDR_I == word_at(`ESR_OFS_DB_ROUTE, i)) begin
               next_s.rdata = s.db_route[i];
            end
         end
         for (int d = 0; d < `ESR_NUM_DB; d++) begin
            if (ADDR_I == word_at(`ESR_OFS_DB_STATUS, d)) begin
               next_s.rdata = {16'h0000, s.db_status[d]};
            end
         end
      end
   end

   // Clock enable low freezes every flag, route and read word
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         s <= '0;
      end else if (CE_I) begin
         s <= next_s;
      end
   end

   // condition order matches route field order
   // Doorbell d condition c sits at index d*16+c, queues follow
   assign pend  = {s.rxq_status, s.db_status};
   assign route = {s.rxq_route, s.db_route};

   esr_route #(
      .NCOND (NCOND),
      .NOUT  (`ESR_NUM_CPU_INT)
   ) u_route (
      .pend_i  (pend),
      .route_i (route),
      .line_o  (CPU_INT_O)
   );

   assign RDATA_O = s.rdata;

   // Event flags reach software through the mask on one level line
   assign IRQ_O = |(s.ev_status & s.ev_mask);

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!ARST_N_I);

   chk_reset_req_set: assert property (
      CE_I && RESET_REQ_I |=> s.ev_status[`ESR_BIT_RESET_REQ])
      else $error("reset request did not set its flag");

   chk_reset_req_hold: assert property (
      s.ev_status[`ESR_BIT_RESET_REQ] && !ev_clr[`ESR_BIT_RESET_REQ]
      |=> s.ev_status[`ESR_BIT_RESET_REQ])
      else $error("reset request flag dropped without a clear");

   chk_log_err_set: assert property (
      CE_I && LOG_ERR_I |=> s.ev_status[`ESR_BIT_LOG_ERR])
      else $error("logical error capture did not set its flag");

   chk_pw_in_set: assert property (
      CE_I && PW_IN_I |=> s.ev_status[`ESR_BIT_PW_IN])
      else $error("port-write request did not set its flag");

   chk_mcast_set: assert property (
      CE_I && MCAST_I |=> s.ev_status[`ESR_BIT_MCAST])
      else $error("multicast symbol did not set its flag");

   chk_port_err_map: assert property (
      CE_I && |PORT_ERR_I |=>
      (s.ev_status[`ESR_BIT_PORT_ERR +: `ESR_NUM_PORTS]
       & $past(PORT_ERR_I)) == $past(PORT_ERR_I))
      else $error("port error flag not at its bit");

   chk_reserved_zero: assert property (
      CE_I && RD_I && ADDR_I == `ESR_OFS_EV_STATUS
      |=> (RDATA_O & ~`ESR_EV_IMPL_MASK) == 32'h0000_0000)
      else $error("reserved status bits read non-zero");

   chk_clear_flag: assert property (
      CE_I && wr_hit(`ESR_OFS_EV_CLEAR) && WDATA_I[`ESR_BIT_LOG_ERR]
      && !LOG_ERR_I |=> !s.ev_status[`ESR_BIT_LOG_ERR])
      else $error("clear write left the flag set");

   chk_db_low_write: assert property (
      CE_I && wr_hit(`ESR_OFS_DB_ROUTE) |=> s.db_route[0] == $past(WDATA_I))
      else $error("doorbell 0 low route word not written");

   chk_db_high_write: assert property (
      CE_I && wr_hit(word_at(`ESR_OFS_DB_ROUTE, 7))
      |=> RD_I && ADDR_I == word_at(`ESR_OFS_DB_ROUTE, 7) && CE_I
      |=> RDATA_O == $past(WDATA_I, 2))
      else $error("doorbell 3 high route word read back wrong");

   chk_rxq_readback: assert property (
      CE_I && RD_I && ADDR_I == `ESR_OFS_RXQ_ROUTE
      |=> RDATA_O == $past(s.rxq_route))
      else $error("queue route register read back wrong");

   chk_rxq_route_out: assert property (
      s.rxq_status[0] |-> CPU_INT_O[s.rxq_route[3:0]])
      else $error("queue 0 condition not on its routed line");

   chk_db_route_out: assert property (
      s.db_status[0][8] |-> CPU_INT_O[s.db_route[1][3:0]])
      else $error("doorbell 0 condition 8 not on its routed line");

   chk_no_stray_int: assert property (
      pend == '0 |-> CPU_INT_O == '0)
      else $error("interrupt line high with nothing pending");

   // Clock enable freeze
   chk_ce_freeze: assert property (
      !CE_I |=> s == $past(s))
      else $error("state moved while clock enable was low");

   // Read data idle
   chk_rdata_idle: assert property (
      CE_I && !RD_I |=> RDATA_O == 32'h0000_0000)
      else $error("read data not zero outside a read answer");

   // Mask opens line
   chk_mask_irq: assert property (
      CE_I && s.ev_status[`ESR_BIT_RESET_REQ] && wr_hit(`ESR_OFS_EV_MASK)
      && WDATA_I[`ESR_BIT_RESET_REQ] |=> IRQ_O)
      else $error("unmasked pending flag left the line low");

   // Mask reserved bits
   chk_mask_reserved: assert property (
      (s.ev_mask & ~`ESR_EV_IMPL_MASK) == 32'h0000_0000)
      else $error("mask holds a reserved bit");

   chk_set_wins: assert property (
      CE_I && MCAST_I && ev_clr[`ESR_BIT_MCAST]
      |=> s.ev_status[`ESR_BIT_MCAST])
      else $error("clear beat a same-cycle multicast event");

   chk_port_clear: assert property (
      CE_I && wr_hit(`ESR_OFS_EV_CLEAR) && WDATA_I[`ESR_BIT_PORT_ERR + 3]
      && !PORT_ERR_I[3] |=> !s.ev_status[`ESR_BIT_PORT_ERR + 3])
      else $error("clear write left port 3 flag set");

   chk_reset_clear: assert property (
      CE_I && wr_hit(`ESR_OFS_EV_CLEAR) && WDATA_I[`ESR_BIT_RESET_REQ]
      && !RESET_REQ_I |=> !s.ev_status[`ESR_BIT_RESET_REQ])
      else $error("clear write left reset flag set");

   chk_status_ro: assert property (
      CE_I && wr_hit(`ESR_OFS_EV_STATUS) && ev_set == 32'h0000_0000
      |=> $stable(s.ev_status))
      else $error("direct write changed the status word");

   // Doorbell flag set
   chk_db_flag_set: assert property (
      CE_I && DB_EVT_I[0] |=> s.db_status[0][0])
      else $error("doorbell 0 condition 0 flag not set");

   // Doorbell flag clear
   chk_db_clear: assert property (
      CE_I && wr_hit(`ESR_OFS_DB_CLEAR) && WDATA_I[0] && !DB_EVT_I[0]
      |=> !s.db_status[0][0])
      else $error("doorbell 0 condition 0 flag not cleared");

   // Queue flag set
   chk_rxq_flag_set: assert property (
      CE_I && RXQ_EVT_I[7] |=> s.rxq_status[7])
      else $error("queue 7 flag not set");

   // Queue flag clear
   chk_rxq_clear: assert property (
      CE_I && wr_hit(`ESR_OFS_RXQ_CLEAR) && WDATA_I[7] && !RXQ_EVT_I[7]
      |=> !s.rxq_status[7])
      else $error("queue 7 flag not cleared");

   chk_db_low_route: assert property (
      s.db_status[2][7] |-> CPU_INT_O[s.db_route[4][31:28]])
      else $error("doorbell 2 condition 7 not on its routed line");

   chk_db_high_route: assert property (
      s.db_status[3][15] |-> CPU_INT_O[s.db_route[7][31:28]])
      else $error("doorbell 3 condition 15 not on its routed line");

   chk_rxq_top_route: assert property (
      s.rxq_status[7] |-> CPU_INT_O[s.rxq_route[31:28]])
      else $error("queue 7 condition not on its routed line");

   cov_reset_req: cover property (
      CE_I && RESET_REQ_I ##1 IRQ_O);
   cov_clear_race: cover property (
      CE_I && MCAST_I && ev_clr[`ESR_BIT_MCAST]);
   cov_db_routed: cover property (
      s.db_status[3][15] && CPU_INT_O[s.db_route[7][31:28]]);
   cov_rxq_routed: cover property (
      s.rxq_status[7] && CPU_INT_O[15]);

endmodule // esr_top

// >>> verification/esr_cpu_model.sv
// CPU interrupt input model: latches every line it sees raised
`timescale 1ns/10ps
module esr_cpu_model (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [15:0] int_i,
   input  wire logic        irq_i,
   output logic      [15:0] taken_o,
   output logic             irq_taken_o
);
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         taken_o     <= 16'h0000;
         irq_taken_o <= 1'b0;
      end else begin
         taken_o     <= taken_o | int_i;
         irq_taken_o <= irq_taken_o | irq_i;
      end
   end
endmodule // esr_cpu_model

// >>> verification/test_event_status_and_routing.sv
// Self-checking bench for the event status and routing block
`timescale 1ns/10ps
module test_event_status_and_routing;
   import esr_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
 $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
   logic        clk, arst_n, wr, rd, rreq, log_err, pw_in, mcast, rd_pend;
   esr_addr_t   addr;
   esr_word_t   wdata, rdata, ev, c, exp_w;
   logic [3:0]  port_err;
   logic [63:0] db_evt;
   logic [7:0]  rxq_evt;
   logic [15:0] cpu_int, taken, seen;
   logic        irq, irq_taken;
   logic        ce;
   esr_word_t   rt [9];
   esr_word_t   q [$];
   int          n_mismatch, n_checks, d, cnd, f;

   esr_top u_esr_top (.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .RESET_REQ_I(rreq), .PORT_ERR_I(port_err), .LOG_ERR_I(log_err),
      .PW_IN_I(pw_in), .MCAST_I(mcast), .DB_EVT_I(db_evt),
      .RXQ_EVT_I(rxq_evt), .CPU_INT_O(cpu_int), .IRQ_O(irq));
   esr_cpu_model u_esr_cpu_model (.clk_i(clk), .arst_n_i(arst_n),
      .int_i(cpu_int), .irq_i(irq), .taken_o(taken),
      .irq_taken_o(irq_taken));

   function automatic esr_addr_t ra(input int i);
      return (i < 8) ? 8'(8'h10 + 4 * i) : 8'h30;
   endfunction
   task automatic wrt(input esr_addr_t a, input esr_word_t v);
      @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask
   task automatic rdt(input esr_addr_t a, input esr_word_t e);
      @(posedge clk); addr <= a; rd <= 1'b1; q.push_back(e);
      @(posedge clk); rd <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) rd_pend <= rd;
   always @(negedge clk) begin
      if (rd_pend) begin
         exp_w = q.pop_front();
         `CHK(rdata, exp_w)
      end
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // A hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      {arst_n, wr, rd, rreq, log_err, pw_in, mcast} = '0;
      ce = 1'b1;
      {addr, wdata, port_err, db_evt, rxq_evt, seen} = '0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      c = $urandom(32'h8205cc85);
      for (int i = 0; i < 9; i++) rdt(ra(i), 32'h0);
      rdt(8'h00, 32'h0);
      $display("test reset values done");
      c = $urandom;
      @(posedge clk); {rreq, log_err, pw_in, mcast} <= 4'hf; port_err <= c[3:0];
      @(posedge clk); {rreq, log_err, pw_in, mcast, port_err} <= '0;
      ev = 32'h0001_0007 | {20'h0, c[3:0], 8'h00};
      rdt(8'h00, ev);
      c = $urandom;
      wrt(8'h04, c);
      rdt(8'h00, ev & ~c);
      rdt(8'h04, 32'h0);
      rdt(8'hfc, 32'h0);
      @(posedge clk); rreq <= 1'b1;
      @(posedge clk); rreq <= 1'b0;
      wrt(8'h08, 32'h0001_0000);
      @(negedge clk); `CHK(irq, 1'b1)
      wrt(8'h04, 32'hffff_ffff);
      @(negedge clk); `CHK(irq, 1'b0)
      rdt(8'h00, 32'h0);
      wrt(8'h00, 32'hffff_ffff);
      rdt(8'h00, 32'h0);
      // An event while the clock enable is low is not taken
      @(posedge clk); ce <= 1'b0; mcast <= 1'b1;
      @(posedge clk); mcast <= 1'b0;
      @(posedge clk); ce <= 1'b1;
      rdt(8'h00, 32'h0);
      $display("test event flags done");
      for (int i = 0; i < 9; i++) begin
         rt[i] = $urandom;
         wrt(ra(i), rt[i]);
      end
      // Read straight after a write, with no idle cycle between
      @(posedge clk); addr <= ra(7); wdata <= ~rt[7]; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0; rd <= 1'b1; q.push_back(~rt[7]);
      @(posedge clk); rd <= 1'b0;
      rt[7] = ~rt[7];
      // Reads of every route word, with one idle cycle between reads
      for (int i = 0; i < 9; i++) rdt(ra(i), rt[i]);
      for (int k = 0; k < 8; k++) begin
         d = $urandom % 4;
         cnd = $urandom % 16;
         f = int'(rt[2 * d + cnd / 8][(cnd % 8) * 4 +: 4]);
         @(posedge clk); db_evt[d * 16 + cnd] <= 1'b1;
         @(posedge clk); db_evt <= '0;
         @(negedge clk); `CHK(cpu_int, 16'h1 << f)
         seen |= 16'h1 << f;
         wrt(8'(8'h50 + 4 * d), 32'h1 << cnd);
         @(negedge clk); `CHK(cpu_int, 16'h0)
         f = int'(rt[8][k * 4 +: 4]);
         @(posedge clk); rxq_evt[k] <= 1'b1;
         @(posedge clk); rxq_evt <= '0;
         @(negedge clk); `CHK(cpu_int, 16'h1 << f)
         seen |= 16'h1 << f;
         wrt(8'h64, 32'h1 << k);
         @(negedge clk); `CHK(cpu_int, 16'h0)
      end
      `CHK(taken, seen)
      `CHK(irq_taken, 1'b1)
      $display("test routing done");
      end_of_test();
   end
endmodule // test_event_status_and_routing
